// *** core/ppm_msg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ppm_msg_if;
  logic fire;
  logic [31:0] lowAddr;
  logic [31:0] upAddr;
  logic [15:0] payload;
  logic wrValid;
  logic wrReady;
  logic wrWide;
  logic [63:0] wrAddr;
  logic [31:0] wrData;
  modport regs (output fire, output lowAddr, output upAddr, output payload, output wrReady,
                input wrValid, input wrWide, input wrAddr, input wrData);
  modport issuer (input fire, input lowAddr, input upAddr, input payload, input wrReady,
                  output wrValid, output wrWide, output wrAddr, output wrData);
endinterface : ppm_msg_if
`default_nettype wire

// *** core/ppm_msg_issuer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppm_msg_issuer (
  input wire logic mclk,
  input wire logic reset_n,
  ppm_msg_if.issuer msg
);
  import ppm_pkg::*;

  logic pending;
  logic next_pending;
  logic valid;
  logic next_valid;
  logic wide;
  logic next_wide;
  logic [63:0] addr;
  logic [63:0] next_addr;
  logic [31:0] data;
  logic [31:0] next_data;
  logic launch;

  // ------------------------------------------------------------
  // Message write request
  // ------------------------------------------------------------
  always_comb begin
    next_pending = pending;
    next_valid = valid;
    next_wide = wide;
    next_addr = addr;
    next_data = data;
    if (valid && msg.wrReady) begin
      next_valid = 1'b0;
    end
    // A trigger while busy is remembered once, not counted
    launch = (msg.fire || pending) && !next_valid;
    if (launch) begin
      next_valid = 1'b1;
      next_pending = 1'b0;
      if (msg.upAddr != 32'h00000000) begin
        next_wide = 1'b1;
        next_addr = {msg.upAddr, msg.lowAddr[31:2], 2'h0};
      end else begin
        next_wide = 1'b0;
        next_addr = {32'h00000000, msg.lowAddr[31:2], 2'h0};
      end
      next_data = {16'h0000, msg.payload};
    end else if (msg.fire) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pending <= 1'b0;
      valid <= 1'b0;
      wide <= 1'b0;
      addr <= 64'h0000000000000000;
      data <= 32'h00000000;
    end else begin
      pending <= next_pending;
      valid <= next_valid;
      wide <= next_wide;
      addr <= next_addr;
      data <= next_data;
    end
  end

  assign msg.wrValid = valid;
  assign msg.wrWide = wide;
  assign msg.wrAddr = addr;
  assign msg.wrData = data;
endmodule : ppm_msg_issuer
`default_nettype wire

// *** core/ppm_pkg.sv ***
package ppm_pkg;
  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_PWRCTL = 12'h0C4;
  localparam logic [11:0] OFF_CAPCTL = 12'h0D0;
  localparam logic [11:0] OFF_LOADDR = 12'h0D4;
  localparam logic [11:0] OFF_UPADDR = 12'h0D8;
  localparam logic [11:0] OFF_MSIDATA = 12'h0DC;
  localparam logic [11:0] OFF_LOCK = 12'h100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PS_LSB = 0;
  localparam int NSR_BIT = 3;
  localparam int WEE_BIT = 8;
  localparam int WES_BIT = 15;
  localparam int CID_LSB = 0;
  localparam int NXT_LSB = 8;
  localparam int MSIEN_BIT = 16;
  localparam int GMC_LSB = 20;
  localparam int WIDE_BIT = 23;
  localparam int ADDR_LSB = 2;
  localparam int LOCK_BIT = 0;

  // ------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3HOT = 2'h3;
  localparam logic [1:0] PS_RST = 2'h0;
  localparam logic NSR_RST = 1'b1;
  localparam logic WEE_RST = 1'b0;
  localparam logic WES_RST = 1'b0;
  localparam logic [7:0] CID_VAL = 8'h05;
  localparam logic [7:0] NXT_RST = 8'h00;
  localparam logic MSIEN_RST = 1'b0;
  localparam logic [2:0] GMC_RST = 3'h0;
  localparam logic WIDE_VAL = 1'b1;
  localparam logic [29:0] ADDR_RST = 30'h00000000;
  localparam logic [31:0] UADDR_RST = 32'h00000000;
  localparam logic [15:0] INTERRUPT_MESSAGE_PAYLOAD_RST = 16'h0000;
  localparam logic LOCK_RST = 1'b0;
endpackage : ppm_pkg

// *** core/ppm_regs.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ppm_regs #(
  parameter bit IS_UPSTREAM = 1'b0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hotReset,
  input wire logic [ppm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wakeEventGen,
  input wire logic wakeEventFwd,
  input wire logic msiRequest,
  input wire logic msiWrReady,
  output logic wakeMsgSend,
  output logic [1:0] powerState,
  output logic contextPreserve,
  output logic contextResetPulse,
  output logic msiEnabled,
  output logic msiWrValid,
  output logic msiWrWide,
  output logic [63:0] msiWrAddr,
  output logic [31:0] msiWrData
);
  import ppm_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [1:0] ps, next_ps;
  logic nsr, next_nsr;
  logic wee, next_wee;
  logic wes, next_wes;
  logic [7:0] nxt, next_nxt;
  logic msiEn, next_msiEn;
  logic [2:0] gmc, next_gmc;
  logic [29:0] loAddr, next_loAddr;
  logic [31:0] upAddr, next_upAddr;
  logic [15:0] interrupt_message_payload, next_interrupt_message_payload;
  logic lockOpen, next_lockOpen;
  logic ctxRst, next_ctxRst;
  logic wakeSend, next_wakeSend;

  logic awReady, next_awReady;
  logic wReady, next_wReady;
  logic awGot, next_awGot;
  logic wGot, next_wGot;
  logic [ADDR_W-1:0] wAddr, next_wAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid;
  logic [1:0] bResp, next_bResp;
  logic arReady, next_arReady;
  logic rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0] rResp, next_rResp;

  logic [31:0] pwrWord;
  logic [31:0] capWord;
  logic [31:0] rdWord;
  logic rdHit;
  logic [31:0] curWord;
  logic [31:0] mrg;
  logic doWrite;

  ppm_msg_if msg ();

  // ------------------------------------------------------------
  // Register images
  // ------------------------------------------------------------
  always_comb begin
    pwrWord = 32'h00000000;
    pwrWord[PS_LSB +: 2] = ps;
    pwrWord[NSR_BIT] = nsr;
    pwrWord[WEE_BIT] = wee;
    pwrWord[WES_BIT] = wes;
    capWord = 32'h00000000;
    capWord[CID_LSB +: 8] = CID_VAL;
    capWord[NXT_LSB +: 8] = nxt;
    capWord[MSIEN_BIT] = msiEn;
    capWord[GMC_LSB +: 3] = gmc;
    capWord[WIDE_BIT] = WIDE_VAL;
  end

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  always_comb begin
    rdWord = 32'h00000000;
    rdHit = 1'b1;
    if (s_axi_araddr == OFF_PWRCTL) begin
      rdWord = pwrWord;
    end else if (s_axi_araddr == OFF_CAPCTL) begin
      rdWord = capWord;
    end else if (s_axi_araddr == OFF_LOADDR) begin
      rdWord = {loAddr, 2'h0};
    end else if (s_axi_araddr == OFF_UPADDR) begin
      rdWord = upAddr;
    end else if (s_axi_araddr == OFF_MSIDATA) begin
      rdWord = {16'h0000, interrupt_message_payload};
    end else if (s_axi_araddr == OFF_LOCK) begin
      rdWord = {31'h00000000, lockOpen};
    end else begin
      rdHit = 1'b0;
    end
  end

  // Current image of the addressed write target, so byte strobes merge cleanly
  always_comb begin
    curWord = 32'h00000000;
    if (wAddr == OFF_PWRCTL) begin
      curWord = pwrWord;
    end else if (wAddr == OFF_CAPCTL) begin
      curWord = capWord;
    end else if (wAddr == OFF_LOADDR) begin
      curWord = {loAddr, 2'h0};
    end else if (wAddr == OFF_UPADDR) begin
      curWord = upAddr;
    end else if (wAddr == OFF_MSIDATA) begin
      curWord = {16'h0000, interrupt_message_payload};
    end else if (wAddr == OFF_LOCK) begin
      curWord = {31'h00000000, lockOpen};
    end
    mrg = apply_strb(curWord, wData, wStrb);
  end

  // ------------------------------------------------------------
  // Bus handshakes
  // ------------------------------------------------------------
  always_comb begin
    next_awReady = awReady;
    next_wReady = wReady;
    next_awGot = awGot;
    next_wGot = wGot;
    next_wAddr = wAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_arReady = arReady;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    doWrite = awGot && wGot && !bValid;
    if (s_axi_awvalid && awReady) begin
      next_awGot = 1'b1;
      next_awReady = 1'b0;
      next_wAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady) begin
      next_wGot = 1'b1;
      next_wReady = 1'b0;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awGot = 1'b0;
      next_wGot = 1'b0;
      next_bValid = 1'b1;
      if (wAddr == OFF_PWRCTL || wAddr == OFF_CAPCTL || wAddr == OFF_LOADDR ||
          wAddr == OFF_UPADDR || wAddr == OFF_MSIDATA || wAddr == OFF_LOCK) begin
        next_bResp = RESP_OKAY;
      end else begin
        next_bResp = RESP_SLVERR;
      end
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
      next_awReady = 1'b1;
      next_wReady = 1'b1;
    end
    if (s_axi_arvalid && arReady) begin
      next_arReady = 1'b0;
      next_rValid = 1'b1;
      next_rData = rdWord;
      next_rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
      next_arReady = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register fields
  // ------------------------------------------------------------
  always_comb begin
    next_ps = ps;
    next_nsr = nsr;
    next_wee = wee;
    next_wes = wes;
    next_nxt = nxt;
    next_msiEn = msiEn;
    next_gmc = gmc;
    next_loAddr = loAddr;
    next_upAddr = upAddr;
    next_interrupt_message_payload = interrupt_message_payload;
    next_lockOpen = lockOpen;
    next_ctxRst = 1'b0;
    if (doWrite) begin
      if (wAddr == OFF_PWRCTL) begin
        if (mrg[PS_LSB +: 2] == PS_D0 || mrg[PS_LSB +: 2] == PS_D3HOT) begin
          next_ps = mrg[PS_LSB +: 2];
          // Leaving D3hot without context preservation drops the message interrupt setup
          if (ps == PS_D3HOT && mrg[PS_LSB +: 2] == PS_D0 && !nsr) begin
            next_ctxRst = 1'b1;
          end
        end
        if (lockOpen) begin
          next_nsr = mrg[NSR_BIT];
        end
        next_wee = mrg[WEE_BIT];
        if (wStrb[1] && wData[WES_BIT]) begin
          next_wes = 1'b0;
        end
      end else if (wAddr == OFF_CAPCTL) begin
        if (lockOpen) begin
          next_nxt = mrg[NXT_LSB +: 8];
        end
        next_msiEn = mrg[MSIEN_BIT];
        next_gmc = mrg[GMC_LSB +: 3];
      end else if (wAddr == OFF_LOADDR) begin
        next_loAddr = mrg[31:ADDR_LSB];
      end else if (wAddr == OFF_UPADDR) begin
        next_upAddr = mrg;
      end else if (wAddr == OFF_MSIDATA) begin
        next_interrupt_message_payload = mrg[15:0];
      end else if (wAddr == OFF_LOCK) begin
        next_lockOpen = mrg[LOCK_BIT];
      end
    end
    // Set after clear: an event in the clearing cycle is kept
    if (wakeEventGen && !IS_UPSTREAM) begin
      next_wes = 1'b1;
    end
    if (next_ctxRst) begin
      next_msiEn = MSIEN_RST;
      next_gmc = GMC_RST;
      next_loAddr = ADDR_RST;
      next_upAddr = UADDR_RST;
      next_interrupt_message_payload = INTERRUPT_MESSAGE_PAYLOAD_RST;
    end
    // Hot reset spares the sticky wake bits
    if (hotReset) begin
      next_ps = PS_RST;
      next_nsr = NSR_RST;
      next_nxt = NXT_RST;
      next_msiEn = MSIEN_RST;
      next_gmc = GMC_RST;
      next_loAddr = ADDR_RST;
      next_upAddr = UADDR_RST;
      next_interrupt_message_payload = INTERRUPT_MESSAGE_PAYLOAD_RST;
      next_lockOpen = LOCK_RST;
      next_ctxRst = 1'b0;
    end
    next_wakeSend = (wakeEventGen && wee && !IS_UPSTREAM) || wakeEventFwd;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ps <= PS_RST;
      nsr <= NSR_RST;
      wee <= WEE_RST;
      wes <= WES_RST;
      nxt <= NXT_RST;
      msiEn <= MSIEN_RST;
      gmc <= GMC_RST;
      loAddr <= ADDR_RST;
      upAddr <= UADDR_RST;
      interrupt_message_payload <= INTERRUPT_MESSAGE_PAYLOAD_RST;
      lockOpen <= LOCK_RST;
      ctxRst <= 1'b0;
      wakeSend <= 1'b0;
      awReady <= 1'b1;
      wReady <= 1'b1;
      awGot <= 1'b0;
      wGot <= 1'b0;
      wAddr <= 12'h000;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= RESP_OKAY;
      arReady <= 1'b1;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= RESP_OKAY;
    end else begin
      ps <= next_ps;
      nsr <= next_nsr;
      wee <= next_wee;
      wes <= next_wes;
      nxt <= next_nxt;
      msiEn <= next_msiEn;
      gmc <= next_gmc;
      loAddr <= next_loAddr;
      upAddr <= next_upAddr;
      interrupt_message_payload <= next_interrupt_message_payload;
      lockOpen <= next_lockOpen;
      ctxRst <= next_ctxRst;
      wakeSend <= next_wakeSend;
      awReady <= next_awReady;
      wReady <= next_wReady;
      awGot <= next_awGot;
      wGot <= next_wGot;
      wAddr <= next_wAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      arReady <= next_arReady;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  // ------------------------------------------------------------
  // Message interrupt issue
  // ------------------------------------------------------------
  // Only one vector exists, so the granted count never alters the payload
  assign msg.fire = msiRequest && msiEn;
  assign msg.lowAddr = {loAddr, 2'h0};
  assign msg.upAddr = upAddr;
  assign msg.payload = interrupt_message_payload;
  assign msg.wrReady = msiWrReady;

  ppm_msg_issuer u_issuer (
    .mclk(mclk),
    .reset_n(reset_n),
    .msg(msg)
  );

  assign s_axi_awready = awReady;
  assign s_axi_wready = wReady;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = arReady;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;
  assign wakeMsgSend = wakeSend;
  assign powerState = ps;
  assign contextPreserve = nsr;
  assign contextResetPulse = ctxRst;
  assign msiEnabled = msiEn;
  assign msiWrValid = msg.wrValid;
  assign msiWrWide = msg.wrWide;
  assign msiWrAddr = msg.wrAddr;
  assign msiWrData = msg.wrData;
endmodule : ppm_regs
`default_nettype wire

// *** tb/ppm_msi_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppm_msi_sink (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic msiWrValid,
  output logic msiWrReady
);
  int seed = int'(32'h1C3A5E77);
  int r;
  initial msiWrReady = 1'b0;
  // Stalls about a quarter of cycles so held message writes get exercised
  always @(posedge mclk) begin
    r = $random(seed);
    msiWrReady <= reset_n && (r[1:0] != 2'h0);
  end
endmodule : ppm_msi_sink
`default_nettype wire

// *** tb/ppm_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic wakeEventGen,
  input wire logic wakeEventFwd,
  input wire logic msiRequest,
  input wire logic msiWrReady,
  input wire logic wakeMsgSend,
  input wire logic [1:0] powerState,
  input wire logic msiEnabled,
  input wire logic msiWrValid,
  input wire logic msiWrWide,
  input wire logic [63:0] msiWrAddr,
  input wire logic [31:0] msiWrData
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_wake_fwd: assert property (wakeEventFwd |=> wakeMsgSend)
    else $error("forwarded wake message lost");
  a_wake_quiet: assert property (!wakeEventGen && !wakeEventFwd |=> !wakeMsgSend)
    else $error("wake message without event");
  a_msi_start: assert property (msiRequest && msiEnabled && !msiWrValid |=> msiWrValid)
    else $error("message write not started");
  a_msi_gate: assert property (!msiEnabled && !msiWrValid |=> !msiWrValid)
    else $error("message write while disabled");
  a_msi_hold: assert property (msiWrValid && !msiWrReady |=> msiWrValid && $stable(msiWrAddr) && $stable(msiWrData))
    else $error("message write changed while stalled");
  a_msi_upper: assert property (msiWrValid |-> msiWrData[31:16] == 16'h0000)
    else $error("message data upper half not zero");
  a_msi_wide: assert property (msiWrValid |-> msiWrWide == (msiWrAddr[63:32] != 32'h0))
    else $error("message address width wrong");
  a_state_legal: assert property (powerState != 2'h1 && powerState != 2'h2)
    else $error("reserved power state entered");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_msi_wide: cover property (msiWrValid && msiWrReady && msiWrWide);
  c_wake: cover property (wakeEventGen ##1 wakeMsgSend);
endmodule : ppm_regs_monitor
bind ppm_regs ppm_regs_monitor mon (.*);
`default_nettype wire

// *** tb/ppm_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_tb;
  import ppm_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, hotReset = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, msiWrData;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic wakeEventGen = 1'b0, wakeEventFwd = 1'b0, msiRequest = 1'b0, msiWrReady;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wakeMsgSend;
  logic contextPreserve, contextResetPulse, msiEnabled, msiWrValid, msiWrWide;
  logic [1:0] s_axi_bresp, s_axi_rresp, powerState;
  logic [63:0] msiWrAddr;
  logic [11:0] addrs[6] = '{OFF_PWRCTL, OFF_CAPCTL, OFF_LOADDR, OFF_UPADDR, OFF_MSIDATA, 12'h0E0};
  int seed = int'(32'hB55EBCD1);
  int mismatches = 0, checks_done = 0;
  bit [1:0] mPs;
  bit mNsr, mWee, mWes, mEn, mLock;
  bit [2:0] mGmc;
  bit [31:0] mLo, mUp, mPl, d;
  bit [96:0] msiQ[$];

  always #4 mclk = ~mclk;
  ppm_regs dut (.*);
  ppm_msi_sink sink (.*);

  // ------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------
  function automatic bit [31:0] mRead(input logic [11:0] a);
    case (a)
      OFF_PWRCTL: return {16'h0000, mWes, 6'h00, mWee, 4'h0, mNsr, 1'b0, mPs};
      OFF_CAPCTL: return {8'h00, 1'b1, mGmc, 3'h0, mEn, 8'h00, 8'h05};
      OFF_LOADDR: return {mLo[31:2], 2'h0};
      OFF_UPADDR: return mUp;
      OFF_MSIDATA: return {16'h0000, mPl[15:0]};
      OFF_LOCK: return {31'h00000000, mLock};
      default: return 32'h0;
    endcase
  endfunction : mRead

  function automatic logic [1:0] mResp(input logic [11:0] a);
    return (a inside {OFF_PWRCTL, OFF_CAPCTL, OFF_LOADDR, OFF_UPADDR, OFF_MSIDATA, OFF_LOCK}) ? 2'h0 : 2'h2;
  endfunction : mResp

  task automatic mReset(input bit full);
    mPs = 2'h0;
    mNsr = 1'b1;
    mEn = 1'b0;
    mGmc = 3'h0;
    mLock = 1'b0;
    mLo = 32'h0;
    mUp = 32'h0;
    mPl = 32'h0;
    if (full) begin
      mWee = 1'b0;
      mWes = 1'b0;
    end
  endtask : mReset

  task automatic chk(input string n, input logic [96:0] e, input logic [96:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bus master: valid and payload held until the sampled ready
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bit ad = 1'b0, wd = 1'b0, bd = 1'b0;
    bit cr;
    cr = (a == OFF_PWRCTL && mPs == 2'h3 && v[1:0] == 2'h0 && !mNsr);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd) begin
      @(posedge mclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (ad && wd && s_axi_bvalid) begin
        bd = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    chk("bresp", mResp(a), s_axi_bresp);
    if (a == OFF_PWRCTL && (v[1:0] == 2'h0 || v[1:0] == 2'h3)) mPs = v[1:0];
    if (a == OFF_PWRCTL) mWee = v[8];
    if (a == OFF_PWRCTL && v[15]) mWes = 1'b0;
    if (a == OFF_PWRCTL && mLock) mNsr = v[3];
    if (a == OFF_CAPCTL) {mGmc, mEn} = {v[22:20], v[16]};
    if (a == OFF_LOADDR) mLo = v;
    if (a == OFF_UPADDR) mUp = v;
    if (a == OFF_MSIDATA) mPl = v;
    if (a == OFF_LOCK) mLock = v[0];
    // Waking without preserved context wipes the message setup
    if (cr) {mEn, mGmc, mLo, mUp, mPl} = 100'h0;
    chk("powerState", mPs, powerState);
    chk("msiEnabled", mEn, msiEnabled);
    chk("contextPreserve", mNsr, contextPreserve);
    chk("contextResetPulse", cr, contextResetPulse);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", mRead(a), s_axi_rdata);
    chk("rresp", mResp(a), s_axi_rresp);
  endtask : rd

  task automatic wake(input bit fwd, input bit exp);
    @(posedge mclk);
    wakeEventFwd <= fwd;
    wakeEventGen <= !fwd;
    @(posedge mclk);
    wakeEventFwd <= 1'b0;
    wakeEventGen <= 1'b0;
    #1;
    chk("wakeMsgSend", exp, wakeMsgSend);
    if (!fwd) mWes = 1'b1;
  endtask : wake

  task automatic msi(input bit on);
    @(posedge mclk);
    msiRequest <= 1'b1;
    @(posedge mclk);
    msiRequest <= 1'b0;
    if (on) msiQ.push_back({mUp != 0, (mUp != 0) ? {mUp, mLo[31:2], 2'h0} : {32'h0, mLo[31:2], 2'h0},
                            16'h0000, mPl[15:0]});
    #1;
    if (!on) chk("msi idle", 1'b0, msiWrValid);
    while (msiQ.size() != 0) @(posedge mclk);
  endtask : msi

  always @(posedge mclk) begin
    if (reset_n && msiWrValid === 1'b1 && msiWrReady === 1'b1) begin
      if (msiQ.size() == 0) chk("msi count", 97'h0, 97'h1);
      else chk("msi write", msiQ.pop_front(), {msiWrWide, msiWrAddr, msiWrData});
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Generous bound: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    mReset(1'b1);
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[1:0] = i[1:0];
      wr(OFF_PWRCTL, d);
      rd(OFF_PWRCTL);
      d = $random(seed);
      wr(OFF_CAPCTL, d);
      rd(OFF_CAPCTL);
    end
    wr(12'h0E0, 32'hFFFFFFFF);
    wr(OFF_PWRCTL, 32'h00008000);
    wake(1'b0, 1'b0);
    rd(OFF_PWRCTL);
    wr(OFF_PWRCTL, 32'h00008000);
    wake(1'b1, 1'b1);
    rd(OFF_PWRCTL);
    wr(OFF_PWRCTL, 32'h00000103);
    wake(1'b0, 1'b1);
    wr(OFF_CAPCTL, 32'h00510000);
    @(posedge mclk);
    hotReset <= 1'b1;
    @(posedge mclk);
    hotReset <= 1'b0;
    mReset(1'b0);
    rd(OFF_PWRCTL);
    rd(OFF_CAPCTL);
    wr(OFF_LOADDR, $random(seed));
    wr(OFF_UPADDR, 32'h0);
    wr(OFF_MSIDATA, $random(seed));
    wr(OFF_CAPCTL, 32'h00010000);
    msi(1'b1);
    wr(OFF_UPADDR, $random(seed) | 1);
    msi(1'b1);
    wr(OFF_PWRCTL, 32'h00000003);
    wr(OFF_PWRCTL, 32'h00000000);
    wr(OFF_LOCK, 32'h00000001);
    rd(OFF_LOCK);
    wr(OFF_PWRCTL, 32'h00000003);
    wr(OFF_PWRCTL, 32'h00000000);
    rd(OFF_CAPCTL);
    rd(OFF_UPADDR);
    wr(OFF_CAPCTL, 32'h00010000);
    msi(1'b1);
    wr(OFF_CAPCTL, 32'h0);
    msi(1'b0);
    finish_test();
  end
endmodule : ppm_regs_tb
`default_nettype wire
